// [rtl/adcsq_ctrl.sv]
// Purpose: Conversion-sequence control with AXI4-Lite registers.
// Assumes: One clock; sample values arrive on sample_data each conversion.
// Notes: Register byte address is four times the register index.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module adcsq_ctrl (
  input wire logic aclk, // Bus clock, 25 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic freeze_req, // Debug breakpoint, asynchronous pin.
  input wire logic [9:0] sample_data, // Converter output for the current conversion.
  output logic irq // Level interrupt.
);
  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  logic [7:0] seq_ctrl_reg;
  logic [1:0] env_reg; // Bit 0 scan, bit 1 sequence-done flag enable.
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [2:0] conv_counter_reg;
  logic [3:0] done_in_seq_reg;
  logic [7:0] ccf_reg;
  logic seq_done_reg;
  logic [adcsq_pkg::RES_W-1:0] result_mem [adcsq_pkg::NUM_RESULTS];
  adcsq_pkg::adcsq_state_t state_reg;
  logic frz_meta_reg;
  logic frz_sync_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic [5:0] word_index(input logic [7:0] byte_addr);
    word_index = byte_addr[7:2];
  endfunction : word_index

  wire aw_have = aw_held_reg || s_axi_awvalid;
  wire w_have = w_held_reg || s_axi_wvalid;
  wire [7:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_fire = aw_have && w_have && !bvalid_reg;
  wire [5:0] wr_idx = word_index(wr_addr);
  wire lane0 = wr_strb[0];
  wire wr_seq = wr_fire && lane0 && (wr_idx == adcsq_pkg::IDX_SEQ_CTRL);
  wire wr_start = wr_fire && lane0 && (wr_idx == adcsq_pkg::IDX_START);
  wire wr_env = wr_fire && lane0 && (wr_idx == adcsq_pkg::IDX_ENV);
  wire wr_istat = wr_fire && lane0 && (wr_idx == adcsq_pkg::IDX_IRQ_STAT);
  wire wr_imask = wr_fire && lane0 && (wr_idx == adcsq_pkg::IDX_IRQ_MASK);
  wire wr_ok = (wr_idx == adcsq_pkg::IDX_SEQ_CTRL) || (wr_idx == adcsq_pkg::IDX_START)
               || (wr_idx == adcsq_pkg::IDX_ENV) || (wr_idx == adcsq_pkg::IDX_IRQ_STAT)
               || (wr_idx == adcsq_pkg::IDX_IRQ_MASK)
               || (wr_idx == adcsq_pkg::IDX_STATUS) || (wr_idx == adcsq_pkg::IDX_DBG_CTRL)
               || (wr_idx[5:3] == adcsq_pkg::IDX_RESULT0[5:3]);

  // Handshake: each write channel is accepted while nothing of it is held and no response is pending.
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------------------------------------
  // Sequence decode and control events
  // ----------------------------------------------------------------------
  logic [3:0] seq_len;
  adcsq_len_decode u_len (
    .len_bits(seq_ctrl_reg[adcsq_pkg::LEN_LSB +: 4]),
    .seq_len(seq_len)
  );

  wire consec = seq_ctrl_reg[adcsq_pkg::CONSEC_BIT];
  wire [1:0] freeze_select = seq_ctrl_reg[adcsq_pkg::FRZ_LSB +: 2];
  wire scan_on = env_reg[0];
  wire seq_irq_en = env_reg[1];
  // Any control write aborts; the sequence-start write then begins anew.
  wire abort = wr_seq || wr_env || wr_start;
  // Code 01 is reserved and treated like continue.
  wire frz_now = frz_sync_reg && (freeze_select == adcsq_pkg::FRZ_NOW);
  wire frz_fin = frz_sync_reg && (freeze_select == adcsq_pkg::FRZ_FINISH);
  wire in_conv = (state_reg == adcsq_pkg::ADCSQ_CONV);
  logic conv_done;
  logic seq_active_reg;
  wire conv_start = (state_reg == adcsq_pkg::ADCSQ_IDLE) && !frz_fin && !frz_now
                    && (seq_active_reg);
  wire last_conv = (done_in_seq_reg + 4'h1) == seq_len;
  wire seq_end = conv_done && last_conv;
  wire [2:0] slot = consec ? conv_counter_reg : done_in_seq_reg[2:0];
  wire seq_done_flag = seq_irq_en ? seq_done_reg : 1'b0;

  // Timer holds while an immediate freeze is active, then resumes.
  adcsq_conv_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(conv_start && !abort),
    .hold(frz_now),
    .abort(abort),
    .done(conv_done)
  );

  // ----------------------------------------------------------------------
  // Freeze synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frz_meta_reg <= 1'b0;
      frz_sync_reg <= 1'b0;
    end else begin
      frz_meta_reg <= freeze_req;
      frz_sync_reg <= frz_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------------
  // The counter is kept in consecutive mode and cleared only by control writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= adcsq_pkg::ADCSQ_IDLE;
      seq_active_reg <= 1'b0;
      done_in_seq_reg <= 4'h0;
      conv_counter_reg <= 3'h0;
      seq_done_reg <= 1'b0;
    end else if (abort) begin
      state_reg <= adcsq_pkg::ADCSQ_IDLE;
      seq_active_reg <= wr_start;
      done_in_seq_reg <= 4'h0;
      conv_counter_reg <= 3'h0;
      seq_done_reg <= wr_start ? 1'b0 : seq_done_reg;
    end else begin
      case (state_reg)
        adcsq_pkg::ADCSQ_IDLE: begin
          if (conv_start) begin
            state_reg <= adcsq_pkg::ADCSQ_CONV;
          end
        end
        adcsq_pkg::ADCSQ_CONV: begin
          if (conv_done) begin
            state_reg <= frz_fin ? adcsq_pkg::ADCSQ_HOLD : adcsq_pkg::ADCSQ_IDLE;
            // Wraps past the last slot by natural overflow.
            conv_counter_reg <= conv_counter_reg + 3'h1;
            done_in_seq_reg <= last_conv ? 4'h0 : done_in_seq_reg + 4'h1;
            if (seq_end) begin
              seq_done_reg <= 1'b1;
              seq_active_reg <= scan_on;
              if (!consec) begin
                conv_counter_reg <= 3'h0;
              end
            end else if (!consec) begin
              conv_counter_reg <= done_in_seq_reg[2:0] + 3'h1;
            end
          end
        end
        adcsq_pkg::ADCSQ_HOLD: begin
          if (!frz_fin) begin
            state_reg <= adcsq_pkg::ADCSQ_IDLE;
          end
        end
        default: state_reg <= adcsq_pkg::ADCSQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Results and complete flags
  // ----------------------------------------------------------------------
  // A start write clears the flags; a result sets its own, start wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ccf_reg <= 8'h00;
    end else begin
      ccf_reg <= (wr_start ? 8'h00 : ccf_reg)
                 | ((in_conv && conv_done && !abort) ? (8'h01 << slot) : 8'h00);
    end
  end

  always_ff @(posedge aclk) begin
    if (in_conv && conv_done && !abort) begin
      result_mem[slot] <= sample_data;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes and interrupt
  // ----------------------------------------------------------------------
  wire [1:0] irq_events = {seq_end && in_conv && !abort, conv_done && in_conv && !abort};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_ctrl_reg <= adcsq_pkg::SEQ_CTRL_RESET;
      env_reg <= 2'h0;
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
    end else begin
      if (wr_seq) begin
        seq_ctrl_reg <= wr_data[7:0] & adcsq_pkg::SEQ_CTRL_MASK;
      end
      if (wr_env) begin
        env_reg <= wr_data[1:0];
      end
      if (wr_imask) begin
        irq_mask_reg <= wr_data[1:0];
      end
      // Set wins over write-one-to-clear in the same cycle.
      irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? wr_data[1:0] : 2'h0)) | irq_events;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------------
  // AXI4-Lite channel state
  // ----------------------------------------------------------------------
  // Address and data may arrive in either order; each is held until paired.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= adcsq_pkg::RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? adcsq_pkg::RESP_OKAY : adcsq_pkg::RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_reg <= 1'b1;
          awaddr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_reg <= 1'b1;
          wdata_reg <= s_axi_wdata;
          wstrb_reg <= s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  // Read mux; the status word shows the counter, flags and freeze state.
  wire [5:0] rd_idx = word_index(s_axi_araddr);
  wire [31:0] status_word = {20'h00000, ccf_reg, frz_sync_reg, conv_counter_reg};
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (rd_idx == adcsq_pkg::IDX_SEQ_CTRL) begin
      rd_word = {24'h000000, seq_ctrl_reg};
    end else if (rd_idx == adcsq_pkg::IDX_STATUS) begin
      rd_word = status_word;
    end else if (rd_idx == adcsq_pkg::IDX_ENV) begin
      rd_word = {29'h00000000, seq_done_flag, env_reg};
    end else if (rd_idx == adcsq_pkg::IDX_IRQ_STAT) begin
      rd_word = {30'h00000000, irq_stat_reg};
    end else if (rd_idx == adcsq_pkg::IDX_IRQ_MASK) begin
      rd_word = {30'h00000000, irq_mask_reg};
    end else if (rd_idx == adcsq_pkg::IDX_START || rd_idx == adcsq_pkg::IDX_DBG_CTRL) begin
      rd_word = 32'h00000000;
    end else if (rd_idx[5:3] == adcsq_pkg::IDX_RESULT0[5:3]) begin
      rd_word = {22'h000000, result_mem[rd_idx[2:0]]};
    end else begin
      rd_word = 32'h00000000;
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= adcsq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_ok ? adcsq_pkg::RESP_OKAY : adcsq_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule : adcsq_ctrl

// [rtl/adcsq_pkg.sv]
// Purpose: Shared constants for the conversion-sequence control block.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes: Register byte address is four times the register index.
package adcsq_pkg;
  // ----------------------------------------------------------------------
  // Register indices and address width
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_SEQ_CTRL = 6'h03;
  localparam logic [5:0] IDX_STATUS = 6'h06;
  localparam logic [5:0] IDX_START = 6'h05;
  localparam logic [5:0] IDX_ENV = 6'h08;
  localparam logic [5:0] IDX_DBG_CTRL = 6'h09;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h0A;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h0B;
  localparam logic [5:0] IDX_RESULT0 = 6'h10;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------------
  // Field layout of sequence_control
  // ----------------------------------------------------------------------
  localparam int LEN_LSB = 3;
  localparam int CONSEC_BIT = 2;
  localparam int FRZ_LSB = 0;
  localparam logic [7:0] SEQ_CTRL_RESET = 8'h20;
  localparam logic [7:0] SEQ_CTRL_MASK = 8'h7F;

  // ----------------------------------------------------------------------
  // Freeze codes, sizes and timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] FRZ_CONTINUE = 2'h0;
  localparam logic [1:0] FRZ_FINISH = 2'h2;
  localparam logic [1:0] FRZ_NOW = 2'h3;
  localparam int NUM_RESULTS = 8;
  localparam int RES_W = 10;
  localparam logic [3:0] LEN_FULL = 4'h8;
  localparam logic [7:0] CONV_CYCLES = 8'h0E;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Interrupt status bits: conversion done, sequence done.
  localparam int IRQ_CONV = 0;
  localparam int IRQ_SEQ = 1;

  typedef enum logic [2:0] {
    ADCSQ_IDLE = 3'h1,
    ADCSQ_CONV = 3'h2,
    ADCSQ_HOLD = 3'h4
  } adcsq_state_t;
endpackage : adcsq_pkg

// [rtl/adcsq_len_decode.sv]
// Purpose: Turns the four length bits into a conversion count.
// Assumes: Pure combinational.
// Notes: Count is one to eight.
`timescale 1ns/1ps
module adcsq_len_decode (
  input wire logic [3:0] len_bits, // Length field 8,4,2,1.
  output logic [3:0] seq_len // Conversions per sequence.
);
  // Code zero and any code with the eight bit set give a full sequence.
  assign seq_len = (len_bits[3] || (len_bits == 4'h0)) ? adcsq_pkg::LEN_FULL
                   : len_bits;
endmodule : adcsq_len_decode

// [rtl/adcsq_conv_timer.sv]
// Purpose: Models the duration of one conversion as a cycle count.
// Assumes: Counting pauses while hold is high.
// Notes: Pulses done for one cycle at the end of a conversion.
`timescale 1ns/1ps
module adcsq_conv_timer (
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic start, // Begin a conversion.
  input wire logic hold, // Suspend counting.
  input wire logic abort, // Drop the conversion.
  output logic done // One-cycle end-of-conversion pulse.
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic run_reg;
  logic run_next;
  wire last = run_reg && (cnt_reg == adcsq_pkg::CONV_CYCLES);

  // Counter advances only while running and not held.
  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    if (abort) begin
      run_next = 1'b0;
      cnt_next = 8'h00;
    end else if (start) begin
      run_next = 1'b1;
      cnt_next = 8'h00;
    end else if (run_reg && !hold) begin
      if (last) begin
        run_next = 1'b0;
      end
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 8'h00;
      run_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end

  assign done = last && !hold && !abort;
endmodule : adcsq_conv_timer

// [verification/adcsq_ctrl_sva.sv]
// Purpose: Port-level checks for the conversion-sequence control block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound into every instance of the top module.
`timescale 1ns/1ps
module adcsq_ctrl_sva (
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic [1:0] s_axi_rresp, // Read response.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic irq // Level interrupt.
);
  // ------------------------------------------------------------------
  // Read address tracking
  // ------------------------------------------------------------------
  localparam logic [7:0] A_SEQ = {adcsq_pkg::IDX_SEQ_CTRL, 2'h0};
  localparam logic [7:0] A_STAT = {adcsq_pkg::IDX_STATUS, 2'h0};
  logic [7:0] rd_addr_reg;

  // Keeps the address of the read in flight, so its data can be judged.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_reg <= s_axi_araddr;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------------
  // Bus handshake, register read and reset interrupt checks
  // ------------------------------------------------------------------
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not the inverse of rvalid");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while response pending");
  AST_SLVERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == adcsq_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read returns data");
  AST_SEQ_READ: assert property (s_axi_rvalid && rd_addr_reg == A_SEQ |->
    s_axi_rdata[31:7] == 25'h0 && s_axi_rresp == adcsq_pkg::RESP_OKAY)
    else $error("sequence control read has stray bits");
  AST_STAT_READ: assert property (s_axi_rvalid && rd_addr_reg == A_STAT |->
    s_axi_rdata[31:12] == 20'h0) else $error("status read has stray bits");
  AST_IRQ_RESET: assert property ($rose(aresetn) |-> !irq)
    else $error("interrupt high after reset");
endmodule : adcsq_ctrl_sva

bind adcsq_ctrl adcsq_ctrl_sva u_adcsq_ctrl_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// [verification/adcsq_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the conversion-sequence control block.
// Assumes: 25 MHz clock, bench acts as AXI4-Lite master.
// Notes: Sequence completion is awaited on the interrupt pin.
`timescale 1ns/1ps
module adcsq_ctrl_tb_top;
  localparam logic [7:0] A_SEQ = {adcsq_pkg::IDX_SEQ_CTRL, 2'h0};
  localparam logic [7:0] A_GO = {adcsq_pkg::IDX_START, 2'h0};
  localparam logic [7:0] A_STAT = {adcsq_pkg::IDX_STATUS, 2'h0};
  localparam logic [7:0] A_ENV = {adcsq_pkg::IDX_ENV, 2'h0};
  localparam logic [7:0] A_IST = {adcsq_pkg::IDX_IRQ_STAT, 2'h0};
  localparam logic [7:0] A_IMSK = {adcsq_pkg::IDX_IRQ_MASK, 2'h0};
  localparam logic [7:0] A_RES = {adcsq_pkg::IDX_RESULT0, 2'h0};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, freeze_req, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
  logic [9:0] sample_data;
  int miscompares = 0;
  int n_checks = 0;

  adcsq_ctrl u_adcsq_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .freeze_req(freeze_req), .sample_data(sample_data), .irq(irq));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Ready stands with the request and drops at the edge that takes the answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    logic dn;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      dn = (s_axi_bvalid === 1'b1);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (dn) begin
        brsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end while (!dn && n < 64);
    if (!dn) chk("write timeout", 32'h1, 32'h0);
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    logic dn;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      dn = (s_axi_rvalid === 1'b1);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (dn) begin
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end while (!dn && n < 64);
    if (!dn) chk("read timeout", 32'h1, 32'h0);
    @(posedge aclk);
  endtask : rd

  task automatic wait_irq();
    int n;
    for (n = 0; n < 600 && irq !== 1'b1; n++) @(posedge aclk);
    chk("irq wait", 32'h1, {31'h0, irq});
  endtask : wait_irq

  // Control writes abort, so the flags are cleared after them and before start.
  task automatic run_seq(input logic [7:0] ctl, input logic [7:0] env);
    wr(A_SEQ, {24'h0, ctl});
    wr(A_ENV, {24'h0, env});
    wr(A_IST, 32'h3);
    wr(A_GO, 32'h1);
    wait_irq();
  endtask : run_seq

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rd(A_SEQ);
    chk("seq reset", 32'h20, rdat);
    wr(A_SEQ, 32'h5B, 4'h0);
    rd(A_SEQ);
    chk("strobeless write", 32'h20, rdat);
    rd(8'hFC);
    chk("unmapped resp", {30'h0, adcsq_pkg::RESP_SLVERR}, {30'h0, rrsp});
    wr(8'hFC, 32'h0);
    chk("unmapped wr resp", {30'h0, adcsq_pkg::RESP_SLVERR}, {30'h0, brsp});
    wr(A_IMSK, 32'h2);
    chk("irq idle", 32'h0, {31'h0, irq});
  endtask : t_reset

  task automatic t_len();
    int n;
    for (int c = 0; c < 16; c++) begin
      n = (c == 0 || c > 7) ? 8 : c;
      sample_data <= {6'h2A, c[3:0]};
      run_seq({1'b0, c[3:0], 3'h0}, 8'h00);
      rd(A_STAT);
      chk("len flags", 32'((1 << n) - 1), {24'h0, rdat[11:4]});
      rd(A_RES + 8'(4 * (n - 1)));
      chk("last slot", {22'h0, 6'h2A, c[3:0]}, rdat);
    end
  endtask : t_len

  task automatic t_fifo();
    run_seq(8'h2C, 8'h01);
    rd(A_STAT);
    chk("fifo count", 32'h5, {29'h0, rdat[2:0]});
    wr(A_IST, 32'h2);
    wait_irq();
    rd(A_STAT);
    chk("fifo wrap", 32'hFF2, {20'h0, rdat[11:4], 1'b0, rdat[2:0]});
    wr(A_SEQ, 32'h2C);
    wr(A_IST, 32'h3);
    repeat (80) @(posedge aclk);
    rd(A_STAT);
    chk("abort count", 32'h0, {29'h0, rdat[2:0]});
    rd(A_IST);
    chk("no restart", 32'h0, rdat);
  endtask : t_fifo

  task automatic t_irq();
    run_seq(8'h08, 8'h02);
    rd(A_ENV);
    chk("flag mirror", 32'h1, {31'h0, rdat[2]});
    wr(A_IMSK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(A_IMSK, 32'h2);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(A_IST, 32'h2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    run_seq(8'h08, 8'h00);
    rd(A_ENV);
    chk("flag gated", 32'h0, {31'h0, rdat[2]});
  endtask : t_irq

  task automatic t_frz();
    logic [7:0] fexp [4] = '{8'h03, 8'h03, 8'h01, 8'h00};
    for (int i = 0; i < 4; i++) begin
      wr(A_SEQ, {24'h0, 8'h10 | 8'(i)});
      wr(A_ENV, 32'h0);
      wr(A_IST, 32'h3);
      wr(A_GO, 32'h1);
      // The breakpoint lands in the middle of the first conversion.
      repeat (8) @(posedge aclk);
      freeze_req <= 1'b1;
      repeat (100) @(posedge aclk);
      rd(A_STAT);
      chk("frozen flags", {24'h0, fexp[i]}, {24'h0, rdat[11:4]});
      chk("freeze seen", 32'h1, {31'h0, rdat[3]});
      freeze_req <= 1'b0;
      wait_irq();
      rd(A_STAT);
      chk("resumed flags", 32'h3, {24'h0, rdat[11:4]});
    end
  endtask : t_frz

  task automatic conclude();
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Inputs are quiet at time zero and reset is held for sixteen edges.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
    {s_axi_rready, freeze_req, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, s_axi_wstrb, sample_data} = 46'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_len();
    t_fifo();
    t_irq();
    t_frz();
    conclude();
  end

  // A hang counts against the run and ends it through the same task.
  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    conclude();
  end
endmodule : adcsq_ctrl_tb_top
